// *** fbx_bus_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// far-side bus: drives a word while the exchanger does not
module fbx_bus_model (
  input  wire logic       clock,
  input  wire logic       drive_en,
  input  wire logic [8:0] drive_val,
  input  wire logic       dev_oe,
  input  wire logic [8:0] dev_out,
  output var  logic [8:0] line
);
  logic [8:0] last_q = 9'h000;

  // keep the last real level so a floating bus never looks valid
  always_ff @(posedge clock) begin
    if (dev_oe || drive_en) last_q <= line;
  end

  // far side lets go of a destination port; an idle bus shows ~last
  always_comb line = dev_oe ? dev_out :
                     (drive_en ? drive_val : ~last_q);
endmodule

`default_nettype wire

// *** fbx_defines.vh ***
`ifndef FBX_DEFINES_VH
`define FBX_DEFINES_VH

// ======================================================================
// word and port geometry
`define FBX_PORT_W      9
`define FBX_NPORT       4
`define FBX_SEL_W       5
`define FBX_SRC_W       2

// ======================================================================
// port indices, used both as destination and as source numbers
`define FBX_IDX_L1      2'h0
`define FBX_IDX_R1      2'h1
`define FBX_IDX_L2      2'h2
`define FBX_IDX_R2      2'h3

// ======================================================================
// reset values
`define FBX_CODE_RST    5'h00
`define FBX_EN_RST      4'h0
`define FBX_SRCS_RST    8'h00
`define FBX_DATA_RST    9'h000

// ======================================================================
// buffer between the sampled sources and the destination flops
`define FBX_FIFO_DEPTH  16
`define FBX_FIFO_AW     4

`endif

// *** fbx_exchanger.v ***
`timescale 1ns/10ps
`default_nettype none
`include "fbx_defines.vh"

// Function
// - every port carries a 9-bit word, each path moves all nine bits.
// - load low and disable low at a rising edge captures the select code.
// - load high keeps the route; source words are registered to destinations.
// - a destination holds its last value until a new word is registered.
// - disable high turns every port driver off at once, without a clock.
// - leaving disable needs disable and load low plus an edge; new route used.
// - route changes must not glitch the destination ports.
// - codes 01000..01011 route among the left pair and right pair.
// - codes 01100..01111 route the other way within each pair.
// - codes 10000..10011 route ones and twos across sides.
// - codes 10100..10111 route across sides the other way.
// - codes 11000..11011 route crossed between one and two.
// - codes 11100..11111 route crossed between one and two, other way.
module fbx_exchanger #(
  parameter PORT_W     = `FBX_PORT_W,
  parameter FIFO_DEPTH = `FBX_FIFO_DEPTH,
  parameter FIFO_AW    = `FBX_FIFO_AW
) (
  input  wire                  CLOCK,
  input  wire                  RESET_N,
  input  wire                  CLOCK_EN,
  input  wire                  OUTPUT_DISABLE,
  input  wire                  SELECT_LOAD_N,
  input  wire [`FBX_SEL_W-1:0] FLOW_SELECT,
  input  wire                  DRAIN_HOLD,
  input  wire [PORT_W-1:0]     LEFT_ONE_IN,
  output wire [PORT_W-1:0]     LEFT_ONE_OUT,
  output wire                  LEFT_ONE_OE,
  input  wire [PORT_W-1:0]     RIGHT_ONE_IN,
  output wire [PORT_W-1:0]     RIGHT_ONE_OUT,
  output wire                  RIGHT_ONE_OE,
  input  wire [PORT_W-1:0]     LEFT_TWO_IN,
  output wire [PORT_W-1:0]     LEFT_TWO_OUT,
  output wire                  LEFT_TWO_OE,
  input  wire [PORT_W-1:0]     RIGHT_TWO_IN,
  output wire [PORT_W-1:0]     RIGHT_TWO_OUT,
  output wire                  RIGHT_TWO_OE,
  output wire                  WORD_READY,
  output wire [`FBX_SEL_W-1:0] ROUTE_CODE,
  output wire                  OUTPUTS_OFF
);

  localparam NPORT  = `FBX_NPORT;
  localparam WORD_W = NPORT * PORT_W;

  // ====================================================================
  // declarations

  // routing state, captured only by a load edge
  reg  [`FBX_SEL_W-1:0] route_code_q;
  reg  [NPORT-1:0]      route_en_q;
  reg  [7:0]            route_src_q;

  // disabled flag, set asynchronously by the disable input
  reg                   disabled_q;

  // per destination driver enable and registered data
  reg  [NPORT-1:0]      oe_q;
  reg  [WORD_W-1:0]     out_q;

  // decoded form of the code on the select inputs
  wire [NPORT-1:0]      dec_en;
  wire [7:0]            dec_src;

  // sampled source word, one lane per port
  wire [WORD_W-1:0]     src_word;

  // buffer handshake
  wire                  capture;
  wire                  sample;
  wire                  fifo_clear;
  wire                  fifo_in_ready;
  wire                  fifo_out_valid;
  wire                  fifo_pop;
  wire [WORD_W-1:0]     fifo_word;
  wire                  fifo_word_valid;

  // ====================================================================
  // control decode

  // a load edge; the disable input must be low for the code to take
  assign capture = ~SELECT_LOAD_N & ~OUTPUT_DISABLE;

  // a data edge samples only while enabled and some path exists;
  // with no path there is nobody to deliver to, so nothing is queued
  assign sample = SELECT_LOAD_N & ~OUTPUT_DISABLE & ~disabled_q &
                  (|route_en_q);

  // a new route or a disable throws away words queued for the old one,
  // so a destination never sees a word meant for another route
  assign fifo_clear = capture | disabled_q | OUTPUT_DISABLE;

  // the drain side can be held off, which lets the buffer really fill
  assign fifo_pop = ~DRAIN_HOLD;

  // lane p of the word is the input of port p
  assign src_word = {RIGHT_TWO_IN, LEFT_TWO_IN,
                     RIGHT_ONE_IN, LEFT_ONE_IN};

  // ====================================================================
  // select code decoder
  fbx_route_dec u_dec (
    .code    (FLOW_SELECT),
    .dst_en  (dec_en),
    .dst_src (dec_src)
  );

  // ====================================================================
  // routing state register
  // a load edge replaces the route; any other edge leaves it alone.
  // the route is not touched by the disable input, only its use is.
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      route_code_q <= `FBX_CODE_RST;
      route_en_q   <= `FBX_EN_RST;
      route_src_q  <= `FBX_SRCS_RST;
    end else if (CLOCK_EN) begin
      if (capture) begin
        route_code_q <= FLOW_SELECT;
        route_en_q   <= dec_en;
        route_src_q  <= dec_src;
      end
    end
  end

  // ====================================================================
  // disabled state
  // set at once by the disable input; left only on a load edge with
  // the disable input low, which also brings in the new route
  always @(posedge CLOCK or negedge RESET_N or
           posedge OUTPUT_DISABLE) begin
    if (!RESET_N) begin
      disabled_q <= 1'b0;
    end else if (OUTPUT_DISABLE) begin
      disabled_q <= 1'b1;
    end else if (CLOCK_EN) begin
      if (capture) begin
        disabled_q <= 1'b0;
      end
    end
  end

  // ====================================================================
  // buffer between sampled sources and destination flops
  fbx_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock            (CLOCK),
    .reset_n          (RESET_N),
    .clk_en           (CLOCK_EN),
    .clear            (fifo_clear),
    .in_valid         (sample),
    .in_data          (src_word),
    .in_ready         (fifo_in_ready),
    .out_valid        (fifo_out_valid),
    .out_ready        (fifo_pop),
    .out_data_q       (fifo_word),
    .out_data_valid_q (fifo_word_valid)
  );

  // ====================================================================
  // per destination driver enable and data flop
  genvar d;
  generate
    for (d = 0; d < NPORT; d = d + 1) begin : g_dst
      wire [1:0]        src_idx;
      reg  [PORT_W-1:0] lane;

      assign src_idx = route_src_q[d*2 +: 2];

      // pick the lane of the source port for this destination
      always @* begin
        case (src_idx)
          `FBX_IDX_L1: lane = fifo_word[0*PORT_W +: PORT_W];
          `FBX_IDX_R1: lane = fifo_word[1*PORT_W +: PORT_W];
          `FBX_IDX_L2: lane = fifo_word[2*PORT_W +: PORT_W];
          `FBX_IDX_R2: lane = fifo_word[3*PORT_W +: PORT_W];
          default:     lane = {PORT_W{1'b0}};
        endcase
      end

      // the enable follows the route only at a load edge, so between
      // loads it cannot toggle; the disable input forces it off without
      // a clock. a port that is no destination keeps its driver off.
      always @(posedge CLOCK or negedge RESET_N or
               posedge OUTPUT_DISABLE) begin
        if (!RESET_N) begin
          oe_q[d] <= 1'b0;
        end else if (OUTPUT_DISABLE) begin
          oe_q[d] <= 1'b0;
        end else if (CLOCK_EN) begin
          if (capture) begin
            oe_q[d] <= dec_en[d];
          end
        end
      end

      // data moves only when a buffered word reaches the flop and this
      // port is a destination; otherwise the last level is held
      always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
          out_q[d*PORT_W +: PORT_W] <= `FBX_DATA_RST;
        end else if (CLOCK_EN) begin
          if (fifo_word_valid && route_en_q[d]) begin
            out_q[d*PORT_W +: PORT_W] <= lane;
          end
        end
      end
    end
  endgenerate

  // ====================================================================
  // pins; every output below is a flop or a buffer flag flop
  assign LEFT_ONE_OUT  = out_q[0*PORT_W +: PORT_W];
  assign RIGHT_ONE_OUT = out_q[1*PORT_W +: PORT_W];
  assign LEFT_TWO_OUT  = out_q[2*PORT_W +: PORT_W];
  assign RIGHT_TWO_OUT = out_q[3*PORT_W +: PORT_W];

  // data and enable change from flops only, the enable at a load edge or when the disable input rises, and
  // the data when a buffered word lands, so a port never shows a combinational glitch
  assign LEFT_ONE_OE   = oe_q[0];
  assign RIGHT_ONE_OE  = oe_q[1];
  assign LEFT_TWO_OE   = oe_q[2];
  assign RIGHT_TWO_OE  = oe_q[3];

  // status; a sample while not ready is dropped, the source must wait
  assign WORD_READY    = fifo_in_ready;
  assign ROUTE_CODE    = route_code_q;
  assign OUTPUTS_OFF   = disabled_q;

endmodule

`default_nettype wire

// *** fbx_exchanger_properties.sv ***
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// port checks on the exchanger
module fbx_exchanger_properties #(
  parameter PORT_W = 9
) (
  input wire logic              CLOCK,
  input wire logic              RESET_N,
  input wire logic              CLOCK_EN,
  input wire logic              OUTPUT_DISABLE,
  input wire logic              SELECT_LOAD_N,
  input wire logic [4:0]        FLOW_SELECT,
  input wire logic [PORT_W-1:0] LEFT_ONE_OUT,
  input wire logic              LEFT_ONE_OE,
  input wire logic [PORT_W-1:0] RIGHT_ONE_OUT,
  input wire logic              RIGHT_ONE_OE,
  input wire logic [PORT_W-1:0] LEFT_TWO_OUT,
  input wire logic              LEFT_TWO_OE,
  input wire logic [PORT_W-1:0] RIGHT_TWO_OUT,
  input wire logic              RIGHT_TWO_OE,
  input wire logic              WORD_READY,
  input wire logic [4:0]        ROUTE_CODE,
  input wire logic              OUTPUTS_OFF
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // ======================================================================
  // helpers
  wire [3:0] oe = {RIGHT_TWO_OE, LEFT_TWO_OE, RIGHT_ONE_OE, LEFT_ONE_OE};
  wire [4*PORT_W-1:0] outs = {RIGHT_TWO_OUT, LEFT_TWO_OUT,
                              RIGHT_ONE_OUT, LEFT_ONE_OUT};
  wire ld = CLOCK_EN && !SELECT_LOAD_N && !OUTPUT_DISABLE;

  // ======================================================================
  // assertions
  a_disable_drops_oe: assert property (
    OUTPUT_DISABLE |-> oe == 4'h0 && OUTPUTS_OFF) else $error("oe on");
  a_load_takes_code: assert property (
    ld |=> ROUTE_CODE == $past(FLOW_SELECT)) else $error("code lost");
  a_other_keeps_route: assert property (
    !ld |=> $stable(ROUTE_CODE)) else $error("route moved");
  a_load_wakes_oe: assert property (
    ld && FLOW_SELECT[1:0] != 2'h0 |=> (!OUTPUTS_OFF && oe != 4'h0)
    || OUTPUT_DISABLE) else $error("no drivers after load");
  a_unused_no_drive: assert property (
    ROUTE_CODE[1:0] == 2'h0 |-> oe == 4'h0) else $error("unused drives");
  a_off_no_drive: assert property (
    OUTPUTS_OFF |-> oe == 4'h0) else $error("off but driving");
  a_wake_by_load: assert property (
    $fell(OUTPUTS_OFF) && $past(RESET_N) |-> $past(ld))
    else $error("woke without load");
  a_single_path: assert property (
    ROUTE_CODE == 5'h12 && !OUTPUTS_OFF |-> oe == 4'h1)
    else $error("wrong path");
  a_frozen_hold: assert property (
    !CLOCK_EN |=> $stable(outs)) else $error("out moved while frozen");

  // main scenarios
  cover property (ld && FLOW_SELECT == 5'h1F);
  cover property ($fell(OUTPUTS_OFF));
  cover property (!WORD_READY);
endmodule

bind fbx_exchanger fbx_exchanger_properties #(.PORT_W(PORT_W)) u_props (
  .CLOCK          (CLOCK),
  .RESET_N        (RESET_N),
  .CLOCK_EN       (CLOCK_EN),
  .OUTPUT_DISABLE (OUTPUT_DISABLE),
  .SELECT_LOAD_N  (SELECT_LOAD_N),
  .FLOW_SELECT    (FLOW_SELECT),
  .LEFT_ONE_OUT   (LEFT_ONE_OUT),
  .LEFT_ONE_OE    (LEFT_ONE_OE),
  .RIGHT_ONE_OUT  (RIGHT_ONE_OUT),
  .RIGHT_ONE_OE   (RIGHT_ONE_OE),
  .LEFT_TWO_OUT   (LEFT_TWO_OUT),
  .LEFT_TWO_OE    (LEFT_TWO_OE),
  .RIGHT_TWO_OUT  (RIGHT_TWO_OUT),
  .RIGHT_TWO_OE   (RIGHT_TWO_OE),
  .WORD_READY     (WORD_READY),
  .ROUTE_CODE     (ROUTE_CODE),
  .OUTPUTS_OFF    (OUTPUTS_OFF)
);

`default_nettype wire

// *** fbx_exchanger_test.sv ***
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// bench: route table, buffer fill and drain, disable and wake
module fbx_exchanger_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        od = 1'b0;
  logic        sl_n = 1'b1;
  logic [4:0]  fs = 5'h00;
  logic        hold = 1'b0;
  logic [3:0]  den = 4'h0;
  logic [8:0]  dval [4] = '{default: 9'h000};
  logic [8:0]  q [$];
  logic [8:0]  got [$];
  logic [8:0]  last;
  wire  [8:0]  pin [4];
  wire  [8:0]  dout [4];
  wire  [3:0]  oe;
  wire         rdy;
  wire  [4:0]  rc;
  wire         off;
  int          errors = 0;
  int          checks = 0;
  // per code, nibble d = {enable, source} of destination d
  logic [15:0] rt [32] = '{
    16'h0000, 16'h0740, 16'h5006, 16'h0067, 16'h0000, 16'h6005,
    16'h5400, 16'h4500, 16'h0000, 16'h6000, 16'h0070, 16'h0007,
    16'h0000, 16'h0700, 16'h5000, 16'h0060, 16'h0000, 16'h0040,
    16'h0006, 16'h0500, 16'h0000, 16'h0005, 16'h0400, 16'h4000,
    16'h0000, 16'h6040, 16'h0076, 16'h0507, 16'h0000, 16'h0705,
    16'h0470, 16'h4060};

  initial forever #2 clk = ~clk;

  // one far-side bus per port
  for (genvar i = 0; i < 4; i++) begin : g_bus
    fbx_bus_model m (
      .clock    (clk),
      .drive_en (den[i]),
      .drive_val(dval[i]),
      .dev_oe   (oe[i]),
      .dev_out  (dout[i]),
      .line     (pin[i])
    );
  end

  fbx_exchanger dut (
    .CLOCK         (clk),
    .RESET_N       (rst_n),
    .CLOCK_EN      (ce),
    .OUTPUT_DISABLE(od),
    .SELECT_LOAD_N (sl_n),
    .FLOW_SELECT   (fs),
    .DRAIN_HOLD    (hold),
    .LEFT_ONE_IN   (pin[0]),
    .LEFT_ONE_OUT  (dout[0]),
    .LEFT_ONE_OE   (oe[0]),
    .RIGHT_ONE_IN  (pin[1]),
    .RIGHT_ONE_OUT (dout[1]),
    .RIGHT_ONE_OE  (oe[1]),
    .LEFT_TWO_IN   (pin[2]),
    .LEFT_TWO_OUT  (dout[2]),
    .LEFT_TWO_OE   (oe[2]),
    .RIGHT_TWO_IN  (pin[3]),
    .RIGHT_TWO_OUT (dout[3]),
    .RIGHT_TWO_OE  (oe[3]),
    .WORD_READY    (rdy),
    .ROUTE_CODE    (rc),
    .OUTPUTS_OFF   (off)
  );

  // ======================================================================
  // tasks
  task automatic chk(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [3:0] en4(input logic [4:0] c);
    en4 = {rt[c][14], rt[c][10], rt[c][6], rt[c][2]};
  endfunction

  // called at a falling edge; one load edge, then back to data edges
  task automatic load(input logic [4:0] c);
    fs = c;
    sl_n = 1'b0;
    @(negedge clk);
    sl_n = 1'b1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ======================================================================
  // watchdog, far longer than the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    $display("Error watchdog expected done seen hang");
    tally_and_finish;
  end

  // ======================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("reset state", 16'h0002, {5'h00, oe, rc, rdy, off});
    // every code: drivers, held route and each path's word
    for (int c = 0; c < 32; c++) begin
      load(c[4:0]);
      chk("route code", 16'(c), {11'h000, rc});
      chk("drivers", {12'h000, en4(c[4:0])}, {12'h000, oe});
      for (int p = 0; p < 4; p++)
        dval[p] = {p[1:0], 2'h2, c[4:0]};
      den = ~en4(c[4:0]);
      repeat (4) @(negedge clk);
      chk("route held", 16'(c), {11'h000, rc});
      for (int d = 0; d < 4; d++)
        if (rt[c][4*d+2])
          chk("out word", {7'h00, dval[rt[c][4*d+:2]]}, {7'h00, dout[d]});
    end
    $display("route test done");
    // fill the buffer with the drain stalled, then drain it
    load(5'h02);
    den = 4'h6;
    hold = 1'b1;
    for (int i = 0; i < 24; i++) begin
      dval[2] = 9'h100 + 9'(i);
      if (rdy) q.push_back(dval[2]);
      @(negedge clk);
    end
    chk("words taken", 16'h0010, 16'(q.size()));
    chk("full", 16'h0000, {15'h0000, rdy});
    hold = 1'b0;
    last = dout[0];
    for (int i = 0; i < 40; i++) begin
      ce = (i != 3);
      @(negedge clk);
      if (dout[0] !== last) got.push_back(dout[0]);
      last = dout[0];
    end
    chk("delivered", 16'h0011, 16'(got.size()));
    for (int i = 0; i < 16 && i < got.size(); i++)
      chk("drained word", {7'h00, q[i]}, {7'h00, got[i]});
    chk("other path", {7'h00, dval[1]}, {7'h00, dout[3]});
    $display("buffer test done");
    // disable without a clock, refused loads, wake by a load edge
    load(5'h19);
    den = 4'h5;
    od = 1'b1;
    #1;
    chk("disabled", 16'h0001, {11'h000, oe, off});
    @(negedge clk);
    fs = 5'h02;
    sl_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("load refused", 16'h0033, {6'h00, oe, rc, off});
    od = 1'b0;
    ce = 1'b0;
    @(negedge clk);
    chk("frozen", 16'h0033, {6'h00, oe, rc, off});
    ce = 1'b1;
    sl_n = 1'b1;
    @(negedge clk);
    chk("data edge stays off", 16'h0033, {6'h00, oe, rc, off});
    load(5'h02);
    chk("woken", 16'h0244, {6'h00, oe, rc, off});
    $display("disable test done");
    tally_and_finish;
  end
endmodule

`default_nettype wire

// *** fbx_fifo.v ***
`timescale 1ns/10ps
`default_nettype none
`include "fbx_defines.vh"

// ======================================================================
// synchronous word buffer; depth must be a power of two
module fbx_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = `FBX_FIFO_DEPTH,
  parameter AW    = `FBX_FIFO_AW
) (
  input  wire             clock,
  input  wire             reset_n,
  input  wire             clk_en,
  input  wire             clear,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output wire             in_ready,
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_q,
  output reg              out_data_valid_q
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  reg [AW:0]      count_d;
  reg             ready_q;
  reg             empty_q;
  wire            push;
  wire            pop;

  // flags are flops so the ready seen outside is glitch free;
  // ready is kept as its own flop so no inverter sits on the pin
  assign in_ready  = ready_q;
  assign out_valid = ~empty_q;
  assign push      = in_valid & ready_q;
  assign pop       = out_ready & ~empty_q;

  // ====================================================================
  // occupancy
  always @* begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      count_d = count_q - {{AW{1'b0}}, 1'b1};
    end
  end

  // storage has no reset; only pointers and flags need one
  always @(posedge clock) begin
    if (clk_en && push && !clear) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // ====================================================================
  // pointers, flags and the registered read port
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q         <= {AW{1'b0}};
      rd_ptr_q         <= {AW{1'b0}};
      count_q          <= {(AW+1){1'b0}};
      ready_q          <= 1'b1;
      empty_q          <= 1'b1;
      out_data_q       <= {WIDTH{1'b0}};
      out_data_valid_q <= 1'b0;
    end else if (clk_en) begin
      if (clear) begin
        wr_ptr_q         <= {AW{1'b0}};
        rd_ptr_q         <= {AW{1'b0}};
        count_q          <= {(AW+1){1'b0}};
        ready_q          <= 1'b1;
        empty_q          <= 1'b1;
        out_data_valid_q <= 1'b0;
      end else begin
        if (push) begin
          wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop) begin
          rd_ptr_q   <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
          out_data_q <= mem[rd_ptr_q];
        end
        out_data_valid_q <= pop;
        count_q          <= count_d;
        ready_q          <= (count_d != DEPTH[AW:0]);
        empty_q          <= (count_d == {(AW+1){1'b0}});
      end
    end
  end

endmodule

`default_nettype wire

// *** fbx_route_dec.v ***
`timescale 1ns/10ps
`default_nettype none
`include "fbx_defines.vh"

// ======================================================================
// select code to per-destination enable and source number
module fbx_route_dec (
  input  wire [`FBX_SEL_W-1:0] code,
  output reg  [`FBX_NPORT-1:0] dst_en,
  output reg  [7:0]            dst_src
);

  reg [11:0] r;

  // one path: enable bit of dst at 8+dst, its source at dst*2
  function [11:0] path;
    input [1:0] dst;
    input [1:0] src;
    begin
      path = 12'h000;
      path[8 + dst] = 1'b1;
      path[dst*2 +: 2] = src;
    end
  endfunction

  // case key is written bit 0 first; 00000..00111 drive nothing
  always @* begin
    case ({code[0], code[1], code[2], code[3], code[4]})
      5'h08: r = path(`FBX_IDX_L1, `FBX_IDX_L2) | path(`FBX_IDX_R2, `FBX_IDX_R1);
      5'h09: r = path(`FBX_IDX_L1, `FBX_IDX_L2);
      5'h0A: r = path(`FBX_IDX_R1, `FBX_IDX_R2);
      5'h0B: r = path(`FBX_IDX_L1, `FBX_IDX_L2) | path(`FBX_IDX_R1, `FBX_IDX_R2);
      5'h0C: r = path(`FBX_IDX_L2, `FBX_IDX_L1) | path(`FBX_IDX_R2, `FBX_IDX_R1);
      5'h0D: r = path(`FBX_IDX_L2, `FBX_IDX_L1);
      5'h0E: r = path(`FBX_IDX_R2, `FBX_IDX_R1);
      5'h0F: r = path(`FBX_IDX_L2, `FBX_IDX_L1) | path(`FBX_IDX_R1, `FBX_IDX_R2);
      5'h10: r = path(`FBX_IDX_R1, `FBX_IDX_L1) | path(`FBX_IDX_L2, `FBX_IDX_R2);
      5'h11: r = path(`FBX_IDX_R1, `FBX_IDX_L1);
      5'h12: r = path(`FBX_IDX_R2, `FBX_IDX_L2);
      5'h13: r = path(`FBX_IDX_R1, `FBX_IDX_L1) | path(`FBX_IDX_R2, `FBX_IDX_L2);
      5'h14: r = path(`FBX_IDX_L1, `FBX_IDX_R1) | path(`FBX_IDX_R2, `FBX_IDX_L2);
      5'h15: r = path(`FBX_IDX_L1, `FBX_IDX_R1);
      5'h16: r = path(`FBX_IDX_L2, `FBX_IDX_R2);
      5'h17: r = path(`FBX_IDX_L1, `FBX_IDX_R1) | path(`FBX_IDX_L2, `FBX_IDX_R2);
      5'h18: r = path(`FBX_IDX_L1, `FBX_IDX_R2) | path(`FBX_IDX_R1, `FBX_IDX_L2);
      5'h19: r = path(`FBX_IDX_L2, `FBX_IDX_R1);
      5'h1A: r = path(`FBX_IDX_L1, `FBX_IDX_R2);
      5'h1B: r = path(`FBX_IDX_L1, `FBX_IDX_R2) | path(`FBX_IDX_L2, `FBX_IDX_R1);
      5'h1C: r = path(`FBX_IDX_R2, `FBX_IDX_L1) | path(`FBX_IDX_L2, `FBX_IDX_R1);
      5'h1D: r = path(`FBX_IDX_R2, `FBX_IDX_L1);
      5'h1E: r = path(`FBX_IDX_R1, `FBX_IDX_L2);
      5'h1F: r = path(`FBX_IDX_R2, `FBX_IDX_L1) | path(`FBX_IDX_R1, `FBX_IDX_L2);
      default: r = 12'h000;
    endcase
    dst_en  = r[11:8];
    dst_src = r[7:0];
  end

endmodule

`default_nettype wire
